// ===== shared/asrp_pkg.sv
// package for the serial register port of a three-channel converter
// assumes one core clock domain and one host serial clock domain
package asrp_pkg;

    // ****************************************************************
    // widths and counts
    // ****************************************************************
    localparam int BYTE_W     = 8;
    localparam int RES_W      = 16;
    localparam int CAL_W      = 24;
    localparam int SHIFT_W    = 24;
    localparam int CNT_W      = 5;
    localparam int ONES_W     = 6;
    localparam int ONES_RESET = 32;

    // ****************************************************************
    // communications byte layout and register select codes
    // ****************************************************************
    localparam int COMM_READY_BIT = 7;
    localparam int COMM_RS_HI     = 6;
    localparam int COMM_RS_LO     = 4;
    localparam int COMM_RW_BIT    = 3;

    localparam logic [2:0] REG_COMM  = 3'h0;
    localparam logic [2:0] REG_SETUP = 3'h1;
    localparam logic [2:0] REG_CLOCK = 3'h2;
    localparam logic [2:0] REG_DATA  = 3'h3;
    localparam logic [2:0] REG_ZERO  = 3'h4;
    localparam logic [2:0] REG_FULL  = 3'h5;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0]  SETUP_RST = 8'h01;
    localparam logic [7:0]  CLOCK_RST = 8'h05;
    localparam logic [23:0] ZERO_RST  = 24'h80_0000;
    localparam logic [23:0] FULL_RST  = 24'h50_0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        LNK_COMM  = 3'b001,
        LNK_WRITE = 3'b010,
        LNK_READ  = 3'b100
    } asrp_lnk_t;

    typedef struct packed {
        logic [7:0]       setup;
        logic [7:0]       clock;
        logic [CAL_W-1:0] zero;
        logic [CAL_W-1:0] full;
    } asrp_cfg_t;

    typedef struct packed {
        asrp_lnk_t          phase;
        logic [CNT_W-1:0]   left;
        logic [SHIFT_W-1:0] shift;
        logic [2:0]         rsel;
        logic [6:0]         comm;
        logic [ONES_W-1:0]  ones;
        asrp_cfg_t          cfg;
        logic [RES_W-1:0]   result;
        logic               rdy_s1;
        logic               rdy_s2;
        logic               res_s1;
        logic               res_s2;
        logic               res_seen;
        logic               rd_tgl;
        logic               cfg_tgl;
    } asrp_link_t;

    typedef struct packed {
        logic             ready_n;
        logic             pend;
        logic [RES_W-1:0] stage;
        logic [RES_W-1:0] hold;
        logic             res_tgl;
        logic             rd_s1;
        logic             rd_s2;
        logic             rd_seen;
        logic             cf_s1;
        logic             cf_s2;
        logic             cf_seen;
        asrp_cfg_t        cfg;
    } asrp_core_t;

    localparam asrp_cfg_t CFG_RST = '{setup: SETUP_RST, clock: CLOCK_RST,
                                      zero: ZERO_RST, full: FULL_RST};

    localparam asrp_link_t LINK_RST = '{phase: LNK_COMM, left: CNT_W'(BYTE_W),
                                        cfg: CFG_RST, default: '0};

    localparam asrp_core_t CORE_RST = '{ready_n: 1'b1, cfg: CFG_RST, default: '0};

endpackage : asrp_pkg

// ===== src/asrp_port.sv
// serial register port: host link on serial_clk, converter side on ref_clk
// assumes the host idles serial_clk high, samples on the rising edge,
// and that the converter core pulses result_load once per new result
`timescale 1ns/1ns
`default_nettype none

module asrp_port
    import asrp_pkg::*;
#(
    parameter int RESYNC_ONES = ONES_RESET
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             serial_clk,
    input  wire logic             select_n,
    input  wire logic             data_in,
    output logic                  data_out,
    output logic                  data_out_oe_n,
    output logic                  result_ready_n,
    input  wire logic [RES_W-1:0] result_data,
    input  wire logic             result_load,
    output asrp_cfg_t             cfg_out
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (RESYNC_ONES < 8 || RESYNC_ONES > 63) begin : g_bad_ones
        $error("resync count must lie between 8 and 63");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    asrp_link_t         lk_r;
    asrp_link_t         lk_nxt;
    asrp_core_t         cr_r;
    asrp_core_t         cr_nxt;
    logic               dout_r;
    logic [SHIFT_W-1:0] din_word;
    logic [SHIFT_W-1:0] rd_word;
    logic               ones_hit;
    logic               rd_edge;

    // bits per register, so wide ones build up from two or three whole bytes
    function automatic logic [CNT_W-1:0] reg_width(input logic [2:0] rs);
        logic [CNT_W-1:0] w;
        w = CNT_W'(BYTE_W);
        if (rs == REG_DATA) begin
            w = CNT_W'(RES_W);
        end else if (rs == REG_ZERO || rs == REG_FULL) begin
            w = CNT_W'(CAL_W);
        end
        return w;
    endfunction : reg_width

    // ****************************************************************
    // link domain: decode and shift on rising serial_clk
    // ****************************************************************

    // incoming bit joins below earlier ones, so the first bit ends on top
    assign din_word = {lk_r.shift[SHIFT_W-2:0], data_in};

    // RESYNC_ONES-th consecutive one (32 by default) while not reading forces a fresh command wait
    assign ones_hit = data_in && (lk_r.phase != LNK_READ)
                    && (lk_r.ones == ONES_W'(RESYNC_ONES - 1));

    // read value, left aligned so the top bit goes out first
    always_comb begin
        unique case (din_word[COMM_RS_HI:COMM_RS_LO])
            REG_COMM:  rd_word = {lk_r.rdy_s2, din_word[6:0], 16'h0000};
            REG_SETUP: rd_word = {lk_r.cfg.setup, 16'h0000};
            REG_CLOCK: rd_word = {lk_r.cfg.clock, 16'h0000};
            REG_DATA:  rd_word = {lk_r.result, 8'h00};
            REG_ZERO:  rd_word = lk_r.cfg.zero;
            REG_FULL:  rd_word = lk_r.cfg.full;
            default:   rd_word = 24'h00_0000;               // unused codes read zero
        endcase
    end

    // next link state; all but the synchronisers and the result copy freezes while select is high
    always_comb begin
        lk_nxt        = lk_r;
        // two-flop synchronisers from the core clock
        lk_nxt.rdy_s1 = cr_r.ready_n;
        lk_nxt.rdy_s2 = lk_r.rdy_s1;
        lk_nxt.res_s1 = cr_r.res_tgl;
        lk_nxt.res_s2 = lk_r.res_s1;
        // hold word is static once the toggle moved, safe to copy
        if (lk_r.res_s2 != lk_r.res_seen) begin
            lk_nxt.res_seen = lk_r.res_s2;
            lk_nxt.result   = cr_r.hold;
        end
        if (!select_n) begin
            if (!data_in || lk_r.phase == LNK_READ) begin
                lk_nxt.ones = '0;
            end else if (!ones_hit) begin
                lk_nxt.ones = lk_r.ones + ONES_W'(1);
            end
            lk_nxt.left = lk_r.left - CNT_W'(1);
            unique case (lk_r.phase)
                LNK_COMM: begin
                    lk_nxt.shift = din_word;
                    if (lk_r.left == CNT_W'(1)) begin
                        lk_nxt.left = CNT_W'(BYTE_W);
                        // a set top bit is no command; idle ones stay here
                        if (!din_word[COMM_READY_BIT]) begin
                            lk_nxt.rsel = din_word[COMM_RS_HI:COMM_RS_LO];
                            lk_nxt.comm = din_word[6:0];
                            lk_nxt.left = reg_width(din_word[COMM_RS_HI:COMM_RS_LO]);
                            if (din_word[COMM_RW_BIT]) begin
                                lk_nxt.phase = LNK_READ;
                                lk_nxt.shift = rd_word;
                            end else begin
                                lk_nxt.phase = LNK_WRITE;
                            end
                        end
                    end
                end
                LNK_WRITE: begin
                    lk_nxt.shift = din_word;
                    if (lk_r.left == CNT_W'(1)) begin
                        unique case (lk_r.rsel)
                            REG_COMM:  lk_nxt.comm       = din_word[6:0];
                            REG_SETUP: lk_nxt.cfg.setup  = din_word[7:0];
                            REG_CLOCK: lk_nxt.cfg.clock  = din_word[7:0];
                            REG_ZERO:  lk_nxt.cfg.zero   = din_word;
                            REG_FULL:  lk_nxt.cfg.full   = din_word;
                            default:   lk_nxt.cfg        = lk_r.cfg;  // result is read-only
                        endcase
                        lk_nxt.cfg_tgl = ~lk_r.cfg_tgl;
                        lk_nxt.phase   = LNK_COMM;
                        lk_nxt.left    = CNT_W'(BYTE_W);
                    end
                end
                LNK_READ: begin
                    // input bits are not looked at here at all
                    lk_nxt.shift = {lk_r.shift[SHIFT_W-2:0], 1'b0};
                    if (lk_r.left == CNT_W'(1)) begin
                        lk_nxt.phase = LNK_COMM;
                        lk_nxt.left  = CNT_W'(BYTE_W);
                        if (lk_r.rsel == REG_DATA) begin
                            lk_nxt.rd_tgl = ~lk_r.rd_tgl;
                        end
                    end
                end
            endcase
            // resync leaves register contents as they are
            if (ones_hit) begin
                lk_nxt.phase = LNK_COMM;
                lk_nxt.left  = CNT_W'(BYTE_W);
            end
        end
    end

    // link registers; serial_clk may stop between frames, the result copy and ready synchronisers then wait for its next edges
    always_ff @(posedge serial_clk or posedge reset) begin
        if (reset) begin
            lk_r <= LINK_RST;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // output bit changes on the falling edge, ready for the host's rising edge
    always_ff @(negedge serial_clk or posedge reset) begin
        if (reset) begin
            dout_r <= 1'b1;
        end else begin
            dout_r <= lk_r.shift[SHIFT_W-1];
        end
    end

    // drive only during a selected read so a shared line stays free
    assign data_out      = dout_r;
    assign data_out_oe_n = select_n || (lk_r.phase != LNK_READ);

    // ****************************************************************
    // core domain: ready pin, result hold and config copies
    // ****************************************************************
    assign rd_edge = cr_r.rd_s2 != cr_r.rd_seen;

    always_comb begin
        cr_nxt         = cr_r;
        cr_nxt.rd_s1   = lk_r.rd_tgl;
        cr_nxt.rd_s2   = cr_r.rd_s1;
        cr_nxt.rd_seen = cr_r.rd_s2;
        cr_nxt.cf_s1   = lk_r.cfg_tgl;
        cr_nxt.cf_s2   = cr_r.cf_s1;
        cr_nxt.cf_seen = cr_r.cf_s2;
        // link config is stable long after its toggle moves
        if (cr_r.cf_s2 != cr_r.cf_seen) begin
            cr_nxt.cfg = lk_r.cfg;
        end
        // completed result read; a new result below overrides it
        if (rd_edge) begin
            cr_nxt.ready_n = 1'b1;
        end
        if (cr_r.pend) begin
            cr_nxt.hold    = cr_r.stage;
            cr_nxt.ready_n = 1'b0;
            cr_nxt.res_tgl = ~cr_r.res_tgl;
            cr_nxt.pend    = 1'b0;
        end
        // ready goes high one cycle ahead of the hold update
        if (result_load) begin
            cr_nxt.stage   = result_data;
            cr_nxt.ready_n = 1'b1;
            cr_nxt.pend    = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cr_r <= CORE_RST;
        end else begin
            cr_r <= cr_nxt;
        end
    end

    assign result_ready_n = cr_r.ready_n;
    assign cfg_out        = cr_r.cfg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_ready_high_load: assert property (@(posedge ref_clk) disable iff (reset)
        result_load |=> result_ready_n)
        else $error("ready pin not high after result load");

    a_ready_low_new: assert property (@(posedge ref_clk) disable iff (reset)
        result_load ##1 !result_load |=> !result_ready_n)
        else $error("ready pin not low after result update");

    a_hold_update: assert property (@(posedge ref_clk) disable iff (reset)
        cr_r.pend |=> (cr_r.hold == $past(cr_r.stage)) && $changed(cr_r.res_tgl))
        else $error("result hold not updated with toggle");

    a_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
        rd_edge && !cr_r.pend && !result_load |=> result_ready_n)
        else $error("ready pin not high after result read");

    a_ones_resync: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && ones_hit |=> lk_r.phase == LNK_COMM && lk_r.left == CNT_W'(BYTE_W))
        else $error("ones run did not restore command wait");

    a_write_quiet: assert property (@(posedge serial_clk) disable iff (reset)
        lk_r.phase != LNK_READ |-> data_out_oe_n)
        else $error("data driven outside a read");

    a_read_ignores: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_READ |=> $stable(lk_r.cfg) && $stable(lk_r.comm))
        else $error("registers changed during a read");

    a_comm_to_write: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_COMM && lk_r.left == CNT_W'(1)
        && !lk_r.shift[COMM_READY_BIT-1] && !lk_r.shift[COMM_RW_BIT-1]
        |=> lk_r.phase == LNK_WRITE && lk_r.left == reg_width(lk_r.rsel))
        else $error("write access not set up after command byte");

    a_access_end: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase != LNK_COMM && lk_r.left == CNT_W'(1)
        |=> lk_r.phase == LNK_COMM)
        else $error("no return to command wait after last bit");

    a_read_msb_first: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_READ && lk_r.left > CNT_W'(1)
        |=> lk_r.shift[SHIFT_W-1] == $past(lk_r.shift[SHIFT_W-2]))
        else $error("read bits not leaving top first");

    a_write_msb_first: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_WRITE |=> lk_r.shift[0] == $past(data_in)
        && lk_r.shift[SHIFT_W-1:1] == $past(lk_r.shift[SHIFT_W-2:0]))
        else $error("write bits not entering top first");

    // command decode, line bit, freeze, store and result copy checks on the link side
    a_cmd_refused: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_COMM && lk_r.left == CNT_W'(1)
        && lk_r.shift[COMM_READY_BIT-1] |=> lk_r.phase == LNK_COMM)
        else $error("flagged command byte not discarded");

    a_comm_to_read: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_COMM && lk_r.left == CNT_W'(1)
        && !lk_r.shift[COMM_READY_BIT-1] && lk_r.shift[COMM_RW_BIT-1]
        |=> lk_r.phase == LNK_READ && lk_r.left == reg_width(lk_r.rsel))
        else $error("read access not set up after command byte");

    a_status_bit: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_COMM && lk_r.left == CNT_W'(1)
        && !lk_r.shift[COMM_READY_BIT-1] && lk_r.shift[COMM_RW_BIT-1]
        && lk_r.shift[COMM_RS_HI-1:COMM_RS_LO-1] == REG_COMM
        |=> lk_r.shift[SHIFT_W-1] == $past(lk_r.rdy_s2))
        else $error("status bit not first out of a command read");

    a_read_bit_out: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_READ |-> data_out == lk_r.shift[SHIFT_W-1])
        else $error("read bit on the line not the top shift bit");

    a_select_freeze: assert property (@(posedge serial_clk) disable iff (reset)
        select_n |=> $stable(lk_r.phase) && $stable(lk_r.left) && $stable(lk_r.shift))
        else $error("link state moved while deselected");

    a_write_stores: assert property (@(posedge serial_clk) disable iff (reset)
        !select_n && lk_r.phase == LNK_WRITE && lk_r.left == CNT_W'(1)
        && lk_r.rsel == REG_SETUP |=> lk_r.cfg.setup == $past(din_word[7:0]))
        else $error("setup write not stored");

    a_result_copy: assert property (@(posedge serial_clk) disable iff (reset)
        lk_r.res_s2 != lk_r.res_seen |=> lk_r.result == $past(cr_r.hold))
        else $error("link result copy missed an update");

    // core side: config copy and ready level
    a_cfg_copy: assert property (@(posedge ref_clk) disable iff (reset)
        cr_r.cf_s2 != cr_r.cf_seen |=> cfg_out == $past(lk_r.cfg))
        else $error("config pins not copied from the link");

    a_ready_stands: assert property (@(posedge ref_clk) disable iff (reset)
        !result_ready_n && !result_load && !rd_edge |=> !result_ready_n)
        else $error("ready pin rose without read or new result");

endmodule : asrp_port

`default_nettype wire

// ===== testbench/asrp_host_model.sv
// host side model: drives the serial clock, select and data in, samples data out
// assumes one device on the line; a released data line reads high
`timescale 1ns/1ns
`default_nettype none

module asrp_host_model
    import asrp_pkg::*;
(
    output var logic serial_clk,
    output var logic select_n,
    output var logic data_in,
    input  wire logic data_out,
    input  wire logic data_out_oe_n
);
    // ****************************************************************
    // line and idle levels
    // ****************************************************************
    localparam int HALF = 80;
    wire logic line;

    // released line floats up through the pull-up
    assign line = data_out_oe_n ? 1'b1 : data_out;

    // clock stands high outside frames
    initial begin
        serial_clk = 1'b1;
        select_n   = 1'b1;
        data_in    = 1'b0;
    end

    // ****************************************************************
    // select and frame tasks
    // ****************************************************************
    // select is changed only while the clock stands high
    task automatic set_sel(input logic v);
        select_n = v;
        #HALF;
    endtask : set_sel

    // msb first; read frames toggle data in so ignored bits keep changing
    task automatic xfer(input logic [SHIFT_W-1:0] tx, input int nbits, input logic rd,
                        output logic [SHIFT_W-1:0] rx, output logic bad_oe);
        rx = '0;
        bad_oe = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_clk = 1'b0;
            data_in = rd ? ~data_in : tx[i];
            #HALF;
            if (data_out_oe_n !== ~rd) bad_oe = 1'b1;
            rx[i] = line;
            serial_clk = 1'b1;
            #HALF;
        end
    endtask : xfer
endmodule : asrp_host_model
`default_nettype wire

// ===== testbench/test_adc_serial_register_port.sv
// self-checking bench for the serial register port
// assumes the host model of its own file and the design's package
`timescale 1ns/1ns
`default_nettype none

module test_adc_serial_register_port
    import asrp_pkg::*;
;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam int ONES_N = 16; // shortened resync count
    logic             ref_clk;
    logic             reset;
    logic             result_load;
    logic [RES_W-1:0] result_data;
    wire logic        serial_clk;
    wire logic        select_n;
    wire logic        data_in;
    wire logic        data_out;
    wire logic        data_out_oe_n;
    wire logic        result_ready_n;
    wire asrp_cfg_t   cfg_out;
    asrp_cfg_t        exp_cfg;
    int               errors;
    int               n_compared;
    int               cycles;
    logic [31:0]      seed;

    asrp_port #(.RESYNC_ONES(ONES_N)) dut_u (
        .ref_clk(ref_clk), .reset(reset), .serial_clk(serial_clk), .select_n(select_n),
        .data_in(data_in), .data_out(data_out), .data_out_oe_n(data_out_oe_n),
        .result_ready_n(result_ready_n), .result_data(result_data),
        .result_load(result_load), .cfg_out(cfg_out));

    asrp_host_model host_u (
        .serial_clk(serial_clk), .select_n(select_n), .data_in(data_in),
        .data_out(data_out), .data_out_oe_n(data_out_oe_n));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // hang guard, far above the expected run of about 11000 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic end_sim;
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [SHIFT_W-1:0] seen, input logic [SHIFT_W-1:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // command byte: top bit zero, select code, read flag, low bits unused
    function automatic logic [7:0] cmd(input logic [2:0] code, input logic rd);
        return {1'b0, code, rd, 3'b000};
    endfunction : cmd

    task automatic rnd(output logic [SHIFT_W-1:0] v);
        seed = xs(seed);
        v = seed[SHIFT_W-1:0];
    endtask : rnd

    task automatic wr(input logic [2:0] code, input logic [SHIFT_W-1:0] val, input int nbits);
        logic [SHIFT_W-1:0] rx;
        logic               bad;
        host_u.xfer(SHIFT_W'(cmd(code, 1'b0)), 8, 1'b0, rx, bad);
        check(SHIFT_W'(bad), '0, "drive during command");
        host_u.xfer(val, nbits, 1'b0, rx, bad);
        check(SHIFT_W'(bad), '0, "drive during write");
    endtask : wr

    task automatic rd(input logic [2:0] code, input int nbits, output logic [SHIFT_W-1:0] rx);
        logic bad;
        host_u.xfer(SHIFT_W'(cmd(code, 1'b1)), 8, 1'b0, rx, bad);
        host_u.xfer('0, nbits, 1'b1, rx, bad);
        check(SHIFT_W'(bad), '0, "drive during read");
    endtask : rd

    // pins and serial readback against the expected image
    task automatic check_all;
        logic [SHIFT_W-1:0] rx;
        repeat (8) @(posedge ref_clk);
        check(SHIFT_W'(cfg_out.setup), SHIFT_W'(exp_cfg.setup), "setup pins");
        check(SHIFT_W'(cfg_out.clock), SHIFT_W'(exp_cfg.clock), "clock pins");
        check(cfg_out.zero, exp_cfg.zero, "zero pins");
        check(cfg_out.full, exp_cfg.full, "full pins");
        rd(REG_SETUP, 8, rx);
        check(rx, SHIFT_W'(exp_cfg.setup), "setup read");
        rd(REG_CLOCK, 8, rx);
        check(rx, SHIFT_W'(exp_cfg.clock), "clock read");
        rd(REG_ZERO, 24, rx);
        check(rx, exp_cfg.zero, "zero read");
        rd(REG_FULL, 24, rx);
        check(rx, exp_cfg.full, "full read");
    endtask : check_all

    // one load pulse; ready rises the cycle after, then falls
    task automatic load_res(input logic [RES_W-1:0] v);
        @(posedge ref_clk);
        result_data <= v;
        result_load <= 1'b1;
        @(posedge ref_clk);
        result_load <= 1'b0;
        #1;
        check(SHIFT_W'(result_ready_n), SHIFT_W'(1'b1), "ready before update");
        @(posedge ref_clk);
        #1;
        check(SHIFT_W'(result_ready_n), SHIFT_W'(1'b0), "ready after update");
    endtask : load_res

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin : main
        logic [SHIFT_W-1:0] v;
        logic [SHIFT_W-1:0] v2;
        logic [SHIFT_W-1:0] rx;
        logic               bad;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        seed = 32'h0000_0009;
        reset = 1'b1;
        result_load = 1'b0;
        result_data = '0;
        exp_cfg = CFG_RST;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(SHIFT_W'(result_ready_n), SHIFT_W'(1'b1), "ready after reset");
        host_u.set_sel(1'b0);
        check_all();
        // command and setup byte as one sixteen bit frame
        rnd(v);
        host_u.xfer({8'h00, cmd(REG_SETUP, 1'b0), v[7:0]}, 16, 1'b0, rx, bad);
        check(SHIFT_W'(bad), '0, "drive during frame");
        exp_cfg.setup = v[7:0];
        // clock register with select raised between the bytes
        rnd(v);
        host_u.xfer(SHIFT_W'(cmd(REG_CLOCK, 1'b0)), 8, 1'b0, rx, bad);
        host_u.set_sel(1'b1);
        // clocks while deselected must move nothing
        host_u.xfer(~SHIFT_W'(v[7:0]), 8, 1'b0, rx, bad);
        host_u.set_sel(1'b0);
        host_u.xfer(SHIFT_W'(v[7:0]), 8, 1'b0, rx, bad);
        exp_cfg.clock = v[7:0];
        // zero scale as three separate byte frames
        rnd(v);
        host_u.xfer(SHIFT_W'(cmd(REG_ZERO, 1'b0)), 8, 1'b0, rx, bad);
        for (int b = 2; b >= 0; b--) host_u.xfer(SHIFT_W'(v[b*8 +: 8]), 8, 1'b0, rx, bad);
        exp_cfg.zero = v;
        rnd(v);
        wr(REG_FULL, v, 24);
        exp_cfg.full = v;
        wr(REG_DATA, 24'h00_5A5A, 16);
        check_all();
        // unused select codes read as zero
        for (int c = 6; c <= 7; c++) begin
            rd(3'(c), 8, rx);
            check(rx, '0, "unused code");
        end
        // flagged command byte is dropped; the port still awaits a command
        host_u.xfer(SHIFT_W'(8'h98), 8, 1'b0, rx, bad);
        check(SHIFT_W'(bad), '0, "drive after flagged byte");
        rd(REG_SETUP, 8, rx);
        check(rx, SHIFT_W'(exp_cfg.setup), "read after flagged byte");
        // resync by ones in mid write leaves the register alone
        host_u.xfer(SHIFT_W'(cmd(REG_ZERO, 1'b0)), 8, 1'b0, rx, bad);
        host_u.xfer(24'hFF_FFFF, ONES_N, 1'b0, rx, bad);
        check_all();
        // results: ready pin, status bit and result readback
        for (int k = 0; k < 3; k++) begin
            rnd(v);
            load_res(v[RES_W-1:0]);
            rnd(v2);
            if (k == 1) begin
                // the link copy needs serial edges between two results
                rd(REG_COMM, 8, rx);
                check(rx, 24'h00_0008, "status before second");
                load_res(v2[RES_W-1:0]);
                v = v2;
            end
            rd(REG_COMM, 8, rx);
            check(rx, 24'h00_0008, "status low");
            rd(REG_DATA, 16, rx);
            check(rx, SHIFT_W'(v[RES_W-1:0]), "result read");
            for (int i = 0; i < 40 && result_ready_n !== 1'b1; i++) @(posedge ref_clk);
            check(SHIFT_W'(result_ready_n), SHIFT_W'(1'b1), "ready after read");
            rd(REG_COMM, 8, rx);
            check(rx, 24'h00_0088, "status high");
        end
        end_sim();
    end : main
endmodule : test_adc_serial_register_port
`default_nettype wire
